// ==== core/psls_led_stretcher.sv ====
// Port status indicator driver: eight open-drain active-low lamp pins.
// Assumes port status inputs are synchronous to clock and that the
// function select and pin enables come from a configuration register
// held elsewhere in the chip.
`timescale 1ns/10ps
`default_nettype none
`include "psls_defines.svh"

// Operation
// - MII transmit activity gives 80 ms low pulse
// - Then at least 80 ms high recovery
// - MII receive activity pulse and recovery likewise
// - Link/activity low while linked, high otherwise
// - Link/activity pulses high 80 ms, recovers low
// - Duplex output low full duplex, high unlinked
// - Half duplex collision pulses low, then recovers
// - Speed low at 100, high 10 or unlinked
// - Fast link low only linked at 100
// - Slow link low only linked at 10
// - Activity pulses low, high when unlinked
// - Link output low while port linked
// - MII transmit enable shown unstretched
// - MII receive valid shown unstretched
// - PHY transmit enable shown unstretched
// - PHY receive valid shown unstretched
// - Outputs open-drain and active low
// - Pin drives only when its enable set
// - Two-bit select maps pins to functions
module psls_led_stretcher
	import psls_pkg::*;
#(
	parameter int STRETCH_CYCLES = `PSLS_STRETCH_CYCLES
)
(
	input  wire logic                        clock,                     // System clock
	input  wire logic                        rst_n,                     // Chip reset, async low
	input  wire psls_port_t                  portStatus [`PSLS_NUM_PORTS], // Per-port status
	input  wire logic [1:0]                  indicator_function_select, // Function select
	input  wire logic [`PSLS_NUM_PINS-1:0]   indicator_pin_enable,      // Per-pin enable
	output logic [`PSLS_NUM_PINS-1:0]        indicatorPinOut,           // Pin output level
	output logic [`PSLS_NUM_PINS-1:0]        indicatorPinOe             // High while pulling low
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// A one-cycle stretch would make done true on the entry cycle and the
	// pulse and recovery phases would collapse into single cycles.
	generate
		if (STRETCH_CYCLES < `PSLS_MIN_STRETCH)
		begin : g_bad_stretch
			$error("STRETCH_CYCLES must be at least 2");
		end
	endgenerate

	localparam int CW = $clog2(STRETCH_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(STRETCH_CYCLES - 1);

	// ----------------------------------------
	// Stretcher sources
	// ----------------------------------------
	// 0: MII tx, 1: MII rx, 2: port1 act, 3: port2 act, 4: port1 coll, 5: port2 coll
	localparam int NS = 6;
	wire logic [NS-1:0] evt;
	assign evt[0] = portStatus[`PSLS_PORT_MII].txAct;
	assign evt[1] = portStatus[`PSLS_PORT_MII].rxAct;
	assign evt[2] = portStatus[`PSLS_PORT_ONE].txAct | portStatus[`PSLS_PORT_ONE].rxAct;
	assign evt[3] = portStatus[`PSLS_PORT_TWO].txAct | portStatus[`PSLS_PORT_TWO].rxAct;
	assign evt[4] = portStatus[`PSLS_PORT_ONE].coll & ~portStatus[`PSLS_PORT_ONE].fullDup;
	assign evt[5] = portStatus[`PSLS_PORT_TWO].coll & ~portStatus[`PSLS_PORT_TWO].fullDup;

	wire logic [NS-1:0] pulseOn;

	genvar s;
	generate
		for (s = 0; s < NS; s++)
		begin : g_str
			psls_phase_t     phase_q;
			psls_phase_t     phase_d;
			logic [CW-1:0]   cnt_q;
			logic [CW-1:0]   cnt_d;
			wire logic       done;

			assign done = (cnt_q == LAST);

			always_comb
			begin
				phase_d = phase_q;
				cnt_d   = cnt_q + CW'(1);
				case (phase_q)
					PSLS_IDLE:
					begin
						cnt_d = '0;
						if (evt[s])
							phase_d = PSLS_PULSE;
					end
					PSLS_PULSE:
					begin
						if (done)
						begin
							phase_d = PSLS_HOLD;
							cnt_d   = '0;
						end
					end
					PSLS_HOLD:
					begin
						if (done)
						begin
							phase_d = PSLS_IDLE;
							cnt_d   = '0;
						end
					end
					default:
					begin
						phase_d = PSLS_IDLE;
						cnt_d   = '0;
					end
				endcase
			end

			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					phase_q <= PSLS_IDLE;
					cnt_q   <= '0;
				end
				else
				begin
					phase_q <= phase_d;
					cnt_q   <= cnt_d;
				end
			end

			assign pulseOn[s] = (phase_q == PSLS_PULSE);
		end
	endgenerate

	// ----------------------------------------
	// Indication functions (1 = lamp on)
	// ----------------------------------------
	wire psls_port_t p0 = portStatus[`PSLS_PORT_MII];
	wire psls_port_t p1 = portStatus[`PSLS_PORT_ONE];
	wire psls_port_t p2 = portStatus[`PSLS_PORT_TWO];

	wire logic txP0   = pulseOn[0];
	wire logic rxP0   = pulseOn[1];
	wire logic lnkAct1 = p1.link & ~pulseOn[2];
	wire logic lnkAct2 = p2.link & ~pulseOn[3];
	wire logic fast1  = p1.link & p1.fast & ~pulseOn[2];
	wire logic fast2  = p2.link & p2.fast & ~pulseOn[3];
	wire logic slow1  = p1.link & ~p1.fast & ~pulseOn[2];
	wire logic slow2  = p2.link & ~p2.fast & ~pulseOn[3];
	wire logic dup1   = p1.link & (p1.fullDup | pulseOn[4]);
	wire logic dup2   = p2.link & (p2.fullDup | pulseOn[5]);
	wire logic spd1   = p1.link & p1.fast;
	wire logic spd2   = p2.link & p2.fast;
	wire logic act1   = p1.link & pulseOn[2];
	wire logic act2   = p2.link & pulseOn[3];
	wire logic lnk1   = p1.link;
	wire logic lnk2   = p2.link;

	// ----------------------------------------
	// Pin mapping
	// ----------------------------------------
	// Each code gets a full eight-pin vector of its own, so a change to one
	// code's mapping cannot disturb another code's pins.
	wire logic [1:0] fs = indicator_function_select;
	wire logic f00 = (fs == `PSLS_FUN_00);
	wire logic f01 = (fs == `PSLS_FUN_01);
	wire logic f10 = (fs == `PSLS_FUN_10);
	wire logic f11 = (fs == `PSLS_FUN_11);

	// Code 00b: stretched MII traffic, link/activity, duplex, speed
	wire logic [`PSLS_NUM_PINS-1:0] map00;
	assign map00[7] = rxP0;
	assign map00[6] = lnkAct2;
	assign map00[5] = dup2;
	assign map00[4] = spd2;
	assign map00[3] = txP0;
	assign map00[2] = lnkAct1;
	assign map00[1] = dup1;
	assign map00[0] = spd1;

	// Code 01b: as 00b, with speed-qualified link/activity
	wire logic [`PSLS_NUM_PINS-1:0] map01;
	assign map01[7] = rxP0;
	assign map01[6] = fast2;
	assign map01[5] = dup2;
	assign map01[4] = slow2;
	assign map01[3] = txP0;
	assign map01[2] = fast1;
	assign map01[1] = dup1;
	assign map01[0] = slow1;

	// Code 10b: per-port activity and plain link
	wire logic [`PSLS_NUM_PINS-1:0] map10;
	assign map10[7] = act2;
	assign map10[6] = lnk2;
	assign map10[5] = dup2;
	assign map10[4] = spd2;
	assign map10[3] = act1;
	assign map10[2] = lnk1;
	assign map10[1] = dup1;
	assign map10[0] = spd1;

	// Code 11b: raw MII and PHY strobes, pins 7 and 6 unused
	wire logic [`PSLS_NUM_PINS-1:0] map11;
	assign map11[7] = 1'b0;
	assign map11[6] = 1'b0;
	assign map11[5] = p2.txEn;
	assign map11[4] = p2.rxDv;
	assign map11[3] = p0.txEn;
	assign map11[2] = p0.rxDv;
	assign map11[1] = p1.txEn;
	assign map11[0] = p1.rxDv;

	logic [`PSLS_NUM_PINS-1:0] lampOn;
	logic [`PSLS_NUM_PINS-1:0] assigned;

	assign lampOn = f00 ? map00 : f01 ? map01 : f10 ? map10 : map11;

	// Only pins 7 and 6 lack a function under code 11b; they are released
	// rather than driven off, so the pull-up alone sets their level.
	assign assigned = f11 ? `PSLS_USED_PINS_11 : `PSLS_ALL_PINS;

	// ----------------------------------------
	// Open-drain drivers
	// ----------------------------------------
	// Drive only enabled, assigned pins
	wire logic [`PSLS_NUM_PINS-1:0] active = indicator_pin_enable & assigned;

	// Pull low for lamp on
	// The data bit stays low for good: only the enable moves, so the pin is
	// never driven high and a wired lamp cannot fight another driver.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			indicatorPinOut <= '0;
			indicatorPinOe  <= '0;
		end
		else
		begin
			indicatorPinOut <= '0;
			indicatorPinOe  <= active & lampOn;
		end
	end

endmodule
`default_nettype wire

// ==== shared/psls_defines.svh ====
// Constants for the port status indicator stretcher.
// Assumes a 10 MHz system clock; included by its bare name.
`ifndef PSLS_DEFINES_SVH
`define PSLS_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSLS_STRETCH_MS      80
`define PSLS_CLK_HZ          10000000
`define PSLS_STRETCH_CYCLES  ((`PSLS_STRETCH_MS * `PSLS_CLK_HZ) / 1000)

// ----------------------------------------
// Function select codes
// ----------------------------------------
`define PSLS_FUN_00          2'h0
`define PSLS_FUN_01          2'h1
`define PSLS_FUN_10          2'h2
`define PSLS_FUN_11          2'h3

// ----------------------------------------
// Port indices
// ----------------------------------------
`define PSLS_PORT_MII        0
`define PSLS_PORT_ONE        1
`define PSLS_PORT_TWO        2
`define PSLS_NUM_PORTS       3
`define PSLS_NUM_PINS        8

// ----------------------------------------
// Limits and pin masks
// ----------------------------------------
`define PSLS_MIN_STRETCH     2
`define PSLS_ALL_PINS        8'hFF
`define PSLS_USED_PINS_11    8'h3F

`endif

// ==== shared/psls_pkg.sv ====
// Types for the port status indicator stretcher.
// Assumes psls_defines.svh sits on the include path.
`include "psls_defines.svh"

package psls_pkg;

	// Status of one port as reported by the switch fabric and PHY
	typedef struct packed {
		logic link;     // Valid link
		logic fast;     // 1: 100 Mb/s, 0: 10 Mb/s
		logic fullDup;  // Full duplex
		logic txAct;    // Transmit activity event
		logic rxAct;    // Receive activity event
		logic coll;     // Collision event
		logic txEn;     // Transmit enable toward the PHY or MII
		logic rxDv;     // Receive data valid from the PHY or MII
	} psls_port_t;

	// Stretcher phase
	typedef enum logic [1:0] {
		PSLS_IDLE,
		PSLS_PULSE,
		PSLS_HOLD
	} psls_phase_t;

endpackage

// ==== testbench/psls_lamp_model.sv ====
// Lamp model on the eight open-drain indicator pins.
// Assumes an external pull-up on every pin.
`timescale 1ns/10ps
`default_nettype none
module psls_lamp_model
(
	input  wire logic [7:0] pinOut,  // Pin data
	input  wire logic [7:0] pinOe,   // Pull enables
	output logic [7:0]      pinLevel // Wire level
);
	assign pinLevel = (pinOe & pinOut) | ~pinOe;
endmodule
`default_nettype wire

// ==== testbench/psls_led_stretcher_tb.sv ====
// Bench for the indicator driver, stretch count of four.
// Assumes lamp model and checker compiled before it.
`timescale 1ns/10ps
`default_nettype none
module psls_led_stretcher_tb
	import psls_pkg::*;
;
	localparam int S = 4;
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic [1:0] fn = 2'h0;
	logic [7:0] en = 8'hFF;
	logic [7:0] pout, poe, lvl;
	psls_port_t ps [3] = '{default: '0};
	int         error_cnt = 0;
	int         n_compared = 0;
	always #50 clock = ~clock;
	psls_led_stretcher #(.STRETCH_CYCLES(S)) i_dut (
		.clock(clock), .rst_n(rst_n), .portStatus(ps),
		.indicator_function_select(fn), .indicator_pin_enable(en),
		.indicatorPinOut(pout), .indicatorPinOe(poe));
	psls_lamp_model i_lamp (.pinOut(pout), .pinOe(poe), .pinLevel(lvl));
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] steady(input logic [1:0] f, input logic [3:0] v);
		logic [2:0] g;
		logic       t;
		t = (f == 2'h3);
		g = t ? {v[2], v[3], ~v[3]} : {v[0] & ((f != 2'h1) | v[1]), v[0] & v[2],
			v[0] & (v[1] ^ (f == 2'h1))};
		return {1'b0, t ? {1'b0, g[1:0]} : g, t & v[1], g};
	endfunction
	task t_reset;
		rst_n = 1'b0;
		repeat (16) @(negedge clock);
		check("lamps in reset", lvl, 8'hFF);
		rst_n = 1'b1;
	endtask
	task t_steady;
		for (int f = 0; f < 4; f++)
			for (int v = 0; v < 16; v++)
			begin
				fn = f[1:0];
				ps[1] = {v[0], v[1], v[2], 3'h0, v[3], ~v[3]};
				ps[2] = ps[1];
				ps[0] = {6'h00, v[1], v[2]};
				repeat (2) @(negedge clock);
				check("steady pins", poe, steady(f[1:0], v[3:0]));
			end
		$display("steady functions done");
	endtask
	task t_enable;
		en = 8'h00;
		repeat (2) @(negedge clock);
		check("disabled pins", lvl, 8'hFF);
		en = 8'hFF;
		$display("pin enables done");
	endtask
	// Events held on continuously: busy ones must be absorbed, not queued
	task t_pulse(input logic [1:0] f);
		logic p;
		t_reset;
		fn = f;
		ps[0] = 8'h18;
		ps[1] = 8'h9C;
		ps[2] = 8'h00;
		@(negedge clock);
		for (int k = 1; k <= 4 * S; k++)
		begin
			@(negedge clock);
			// Recovery ends one cycle before idle can take a new event
			p = (((k - 1) % (2 * S + 1)) < S);
			check("stretched pins", poe, (f == 2'h0) ? {p, 3'h0, p, ~p, p, 1'b0} :
				{4'h0, p, 1'b1, p, 1'b0});
		end
		$display("stretch run done");
	endtask
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		t_reset;
		t_steady;
		t_enable;
		t_pulse(2'h0);
		t_pulse(2'h2);
		print_verdict;
	end
	initial
	begin
		#1000000;
		error_cnt++;
		print_verdict;
	end
endmodule
`default_nettype wire

// ==== testbench/psls_props.sv ====
// Checker on the indicator driver ports.
// Assumes a short stretch count in simulation.
`timescale 1ns/10ps
`default_nettype none
module psls_props
	import psls_pkg::*;
#(parameter int STRETCH_CYCLES = 4)
(
	input wire logic       clock,                     // Clock
	input wire logic       rst_n,                     // Reset
	input wire psls_port_t portStatus [3],            // Status
	input wire logic [1:0] indicator_function_select, // Select
	input wire logic [7:0] indicator_pin_enable,      // Enables
	input wire logic [7:0] indicatorPinOut,           // Data
	input wire logic [7:0] indicatorPinOe             // Pulls
);
	wire logic [1:0] fn = indicator_function_select;
	wire logic [7:0] en = indicator_pin_enable;
	wire logic [7:0] oe = indicatorPinOe;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Guarding the previous select covers only the newer registered oe sample, so a switch into code 00b can still pose as a pulse
	sequence txRise;
		fn == 2'h0 && $past(fn) == 2'h0 && $rose(oe[3]);
	endsequence
	sequence txRecover;
		!oe[3] ##1 !oe[3];
	endsequence
	out_zero_a: assert property (indicatorPinOut == 8'h00)
		else $error("pin data not low");
	pin_off_a: assert property (1 |=> (oe & ~$past(en)) == 8'h00)
		else $error("disabled pin pulled");
	sel_off_a: assert property (fn == 2'h3 |=> oe[7:6] == 2'h0)
		else $error("unused pins pulled");
	mii_txen_a: assert property
		(fn == 2'h3 && en[3] |=> oe[3] == $past(portStatus[0].txEn)) else $error("mii txen");
	mii_rxdv_a: assert property
		(fn == 2'h3 && en[2] |=> oe[2] == $past(portStatus[0].rxDv)) else $error("mii rxdv");
	phy_txen_a: assert property
		(fn == 2'h3 && en[1] |=> oe[1] == $past(portStatus[1].txEn)) else $error("phy txen");
	speed_p1_a: assert property
		(fn == 2'h0 && en[0] |=> oe[0] == $past(portStatus[1].link && portStatus[1].fast))
		else $error("speed pin");
	tx_pulse_a: assert property
		(txRise |-> $past(portStatus[0].txAct) ##STRETCH_CYCLES txRecover) else $error("tx pulse");
endmodule
bind psls_led_stretcher psls_props #(.STRETCH_CYCLES(STRETCH_CYCLES)) i_props (
	.clock(clock), .rst_n(rst_n), .portStatus(portStatus),
	.indicator_function_select(indicator_function_select),
	.indicator_pin_enable(indicator_pin_enable),
	.indicatorPinOut(indicatorPinOut), .indicatorPinOe(indicatorPinOe));
`default_nettype wire
